// File: spr_regs.v
// Behaviour
// - received priority is translated via the ingress port table before queue selection.
// - each table holds eight 3-bit fields, priority 7 at 23:21 down to 0 at 2:0.
// - tables reset to identity mapping, 111b for priority 7 down to 000b.
// - port 0 has its own table with same layout and identity default.
// - per port 32-bit counter counts addresses dropped or displaced by full table.
// - reading a counter returns its count then clears it; resets to zero.
// - counters saturate at all ones until cleared by a read.
// - mask bit 0 blocks switch-engine interrupts; resets set.
// - the mask never stops pending status from being set.
// - clearing the mask lets pending status raise the interrupt request.
// - pending flag sets when one or more packet drop events occur.
`include "spr_consts.vh"
`default_nettype none

module spr_regs #(
  parameter AW = 16
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [AW-1:0] wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  input  wire [3:0]    wb_sel_i,
  input  wire          wb_we_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire          rx_valid,
  input  wire [1:0]    rx_port,
  input  wire [2:0]    rx_prio,
  output reg           regen_valid,
  output reg  [2:0]    regen_prio,
  input  wire [2:0]    learn_drop,
  input  wire          pkt_drop,
  output reg           sw_irq,
  output reg           evt_irq
);

// ==========================================================================
// functions
function [2:0] spr_lookup;
  input [`SPR_TBL_W-1:0] tbl;
  input [2:0]            idx;
  begin
    spr_lookup = tbl[idx*`SPR_FLD_W +: `SPR_FLD_W];
  end
endfunction

function [31:0] spr_count;
  input [31:0] cnt;
  input        hit;
  input        clr;
  begin
    if (clr) begin
      spr_count = {31'h00000000, hit};
    end else if (hit && cnt != `SPR_CNT_MAX) begin
      spr_count = cnt + 32'h00000001;
    end else begin
      spr_count = cnt;
    end
  end
endfunction

function [`SPR_TBL_W-1:0] spr_wmask;
  input [`SPR_TBL_W-1:0] old;
  input [31:0]           dat;
  input [3:0]            sel;
  integer i;
  begin
    spr_wmask = old;
    for (i = 0; i < 3; i = i + 1) begin
      if (sel[i]) begin
        spr_wmask[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
  end
endfunction

// ==========================================================================
// state
reg [`SPR_TBL_W-1:0] tbl0_q;
reg [`SPR_TBL_W-1:0] tbl1_q;
reg [`SPR_TBL_W-1:0] tbl2_q;
reg [31:0]           cnt0_q;
reg [31:0]           cnt1_q;
reg [31:0]           cnt2_q;
reg                  imr_q;
reg                  pend_q;
reg [`SPR_EVT_W-1:0] est_q;
reg [`SPR_EVT_W-1:0] emsk_q;

wire [13:0] idx = wb_adr_i[15:2];
wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire        wr  = req && wb_we_i;
wire        rd  = req && !wb_we_i;
wire        cnt_sat = (cnt0_q == `SPR_CNT_MAX) || (cnt1_q == `SPR_CNT_MAX) ||
                      (cnt2_q == `SPR_CNT_MAX);
wire [`SPR_EVT_W-1:0] evt = {cnt_sat, pkt_drop, |learn_drop, 1'b0};

reg [31:0] rdata;
always @* begin
  rdata = 32'h00000000;
  if (idx == `SPR_IDX_TBL0) begin
    rdata = {8'h00, tbl0_q};
  end else if (idx == `SPR_IDX_TBL1) begin
    rdata = {8'h00, tbl1_q};
  end else if (idx == `SPR_IDX_TBL2) begin
    rdata = {8'h00, tbl2_q};
  end else if (idx == `SPR_IDX_CNT0) begin
    rdata = cnt0_q;
  end else if (idx == `SPR_IDX_CNT1) begin
    rdata = cnt1_q;
  end else if (idx == `SPR_IDX_CNT2) begin
    rdata = cnt2_q;
  end else if (idx == `SPR_IDX_IMR) begin
    rdata = {31'h00000000, imr_q};
  end else if (idx == `SPR_IDX_IPR) begin
    rdata = {31'h00000000, pend_q};
  end else if (idx == `SPR_IDX_EVT_STAT) begin
    rdata = {28'h0000000, est_q};
  end else if (idx == `SPR_IDX_EVT_MASK) begin
    rdata = {28'h0000000, emsk_q};
  end
end

// ==========================================================================
// bus slave: one registered ack per request, one cycle after it; unmapped reads return zero
always @(posedge clk or posedge rst) begin
  if (rst) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end else begin
    wb_ack_o <= req;
    wb_dat_o <= rd ? rdata : 32'h00000000;
  end
end

// ==========================================================================
// registers
always @(posedge clk or posedge rst) begin
  if (rst) begin
    tbl0_q <= `SPR_TBL_RST;
    tbl1_q <= `SPR_TBL_RST;
    tbl2_q <= `SPR_TBL_RST;
    cnt0_q <= `SPR_CNT_RST;
    cnt1_q <= `SPR_CNT_RST;
    cnt2_q <= `SPR_CNT_RST;
    imr_q  <= `SPR_IMR_RST;
    pend_q <= 1'b0;
    est_q  <= {`SPR_EVT_W{1'b0}};
    emsk_q <= {`SPR_EVT_W{1'b0}};
  end else begin
    if (wr && idx == `SPR_IDX_TBL0) begin
      tbl0_q <= spr_wmask(tbl0_q, wb_dat_i, wb_sel_i);
    end
    if (wr && idx == `SPR_IDX_TBL1) begin
      tbl1_q <= spr_wmask(tbl1_q, wb_dat_i, wb_sel_i);
    end
    if (wr && idx == `SPR_IDX_TBL2) begin
      tbl2_q <= spr_wmask(tbl2_q, wb_dat_i, wb_sel_i);
    end
    // a drop in the clearing cycle is kept as a count of one
    cnt0_q <= spr_count(cnt0_q, learn_drop[0], rd && idx == `SPR_IDX_CNT0);
    cnt1_q <= spr_count(cnt1_q, learn_drop[1], rd && idx == `SPR_IDX_CNT1);
    cnt2_q <= spr_count(cnt2_q, learn_drop[2], rd && idx == `SPR_IDX_CNT2);
    if (wr && idx == `SPR_IDX_IMR && wb_sel_i[0]) begin
      imr_q <= wb_dat_i[0];
    end
    // pending set regardless of mask; set wins over read clear
    if (pkt_drop) begin
      pend_q <= 1'b1;
    end else if (rd && idx == `SPR_IDX_IPR) begin
      pend_q <= 1'b0;
    end
    if (rd && idx == `SPR_IDX_EVT_STAT) begin
      est_q <= evt;
    end else begin
      est_q <= est_q | evt;
    end
    if (wr && idx == `SPR_IDX_EVT_MASK && wb_sel_i[0]) begin
      emsk_q <= wb_dat_i[`SPR_EVT_W-1:0];
    end
  end
end

// ==========================================================================
// priority regeneration and interrupt outputs
reg [2:0] map;
always @* begin
  case (rx_port)
    2'h1:    map = spr_lookup(tbl1_q, rx_prio);
    2'h2:    map = spr_lookup(tbl2_q, rx_prio);
    default: map = spr_lookup(tbl0_q, rx_prio);
  endcase
end

always @(posedge clk or posedge rst) begin
  if (rst) begin
    regen_valid <= 1'b0;
    regen_prio  <= 3'h0;
    sw_irq      <= 1'b0;
    evt_irq     <= 1'b0;
  end else begin
    regen_valid <= rx_valid;
    regen_prio  <= map;
    // one register stage; the mask change shows one cycle after the write edge
    sw_irq      <= pend_q && !imr_q;
    evt_irq     <= |(est_q & emsk_q);
  end
end

endmodule // spr_regs
`default_nettype wire

// File: spr_consts.vh
`ifndef SPR_CONSTS_VH
`define SPR_CONSTS_VH
// ==========================================================================
// register indices (byte address = 4 * index)
`define SPR_IDX_TBL0      14'h1855
`define SPR_IDX_TBL1      14'h1856
`define SPR_IDX_TBL2      14'h1857
`define SPR_IDX_CNT0      14'h1858
`define SPR_IDX_CNT1      14'h1859
`define SPR_IDX_CNT2      14'h185A
`define SPR_IDX_IMR       14'h1880
`define SPR_IDX_IPR       14'h1881
`define SPR_IDX_EVT_STAT  14'h1890
`define SPR_IDX_EVT_MASK  14'h1891
// ==========================================================================
// field layout and reset values
`define SPR_TBL_W         24
`define SPR_FLD_W         3
`define SPR_TBL_RST       24'hFAC688
`define SPR_CNT_RST       32'h00000000
`define SPR_CNT_MAX       32'hFFFFFFFF
`define SPR_IMR_RST       1'h1
`define SPR_IPR_PEND_BIT  0
`define SPR_EVT_W         4
`endif

// File: spr_regs_checker.sv
`include "spr_consts.vh"
`default_nettype none
// ====
// checker
module spr_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        rx_valid,
  input wire logic [2:0]  rx_prio,
  input wire logic        regen_valid,
  input wire logic [2:0]  regen_prio,
  input wire logic        pkt_drop,
  input wire logic        sw_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic m_q;
  logic w_q;
  // shadow mask; w_q marks any table write so identity is only checked before it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m_q <= 1'h1;
      w_q <= 1'h0;
    end else if (wb_ack_o && wb_we_i) begin
      if (wb_adr_i[15:2] == `SPR_IDX_IMR && wb_sel_i[0]) m_q <= wb_dat_i[0];
      if (wb_adr_i[15:4] == 12'h615) w_q <= 1'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_regen_next: assert property (rx_valid |=> regen_valid) else $error("regen late");
  a_regen_quiet: assert property (!rx_valid |=> !regen_valid) else $error("regen stray");
  a_regen_ident: assert property (rx_valid && !w_q |=> regen_prio == $past(rx_prio))
    else $error("regen not identity");
  a_irq_masked: assert property (m_q && $past(m_q) |-> !sw_irq) else $error("irq unmasked");
  a_irq_raise: assert property (pkt_drop && !m_q ##1 !m_q |=> sw_irq)
    else $error("irq missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data stray");
endmodule // spr_chk
bind spr_regs spr_chk u_chk (.*);
`default_nettype wire

// File: tb_spr_regs.sv
`include "spr_consts.vh"
`default_nettype none
// ====
// bench
module tb_spr_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0;
  logic        rst = 1;
  logic [15:0] adr = 0;
  logic [31:0] wd = 0;
  logic [3:0]  sel = 4'hF;
  logic        we = 0;
  logic        cs = 0;
  logic        rxv = 0;
  logic [1:0]  rxp = 0;
  logic [2:0]  rxq = 0;
  logic [2:0]  ld = 0;
  logic        pd = 0;
  logic [31:0] v;
  logic [23:0] r1;
  logic [23:0] r2;
  wire  [31:0] rd;
  wire         ack;
  wire         rgv;
  wire  [2:0]  rgp;
  wire         irq;
  wire         eirq;
  int          fails = 0;
  int          checks = 0;
  always #20 clk = ~clk;
  spr_regs DUT (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cs), .wb_stb_i(cs), .wb_dat_o(rd), .wb_ack_o(ack),
    .rx_valid(rxv), .rx_port(rxp), .rx_prio(rxq), .regen_valid(rgv), .regen_prio(rgp),
    .learn_drop(ld), .pkt_drop(pd), .sw_irq(irq), .evt_irq(eirq));
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // request held until ack is sampled; release leaves one idle cycle before the next
  task automatic bus(input [13:0] i, input w, input [31:0] d);
    @(posedge clk);
    adr <= {i, 2'h0};
    we <= w;
    wd <= d;
    cs <= 1'h1;
    do @(posedge clk); while (ack !== 1'h1);
    v = rd;
    cs <= 1'h0;
  endtask
  task automatic rdc(input string n, input [13:0] i, input [31:0] e);
    bus(i, 1'h0, 32'h0);
    cmp(n, e, v);
  endtask
  task automatic look(input [1:0] p, input [2:0] q, input [2:0] e);
    @(posedge clk);
    rxv <= 1'h1;
    rxp <= p;
    rxq <= q;
    @(posedge clk);
    rxv <= 1'h0;
    #1 cmp("regen", {29'h0, e}, {29'h0, rgp});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 3; i++) rdc("table", 14'(`SPR_IDX_TBL0 + i), 32'h00FAC688);
    for (int i = 0; i < 3; i++) rdc("count", 14'(`SPR_IDX_CNT0 + i), 32'h0);
    rdc("mask", `SPR_IDX_IMR, 32'h1);
    rdc("unmapped", 14'h1870, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      r1[3*k +: 3] = 3'(7 - k);
      r2[3*k +: 3] = 3'(k + 1);
    end
    bus(`SPR_IDX_TBL1, 1'h1, {8'hFF, r1});
    bus(`SPR_IDX_TBL2, 1'h1, {8'h00, r2});
    rdc("table", `SPR_IDX_TBL1, {8'h00, r1});
    for (int k = 0; k < 8; k++) begin
      look(2'h0, 3'(k), 3'(k));
      look(2'h1, 3'(k), 3'(7 - k));
      look(2'h2, 3'(k), 3'(k + 1));
    end
    $display("table test done");
    @(posedge clk);
    ld <= 3'h5;
    repeat (3) @(posedge clk);
    ld <= 3'h0;
    rdc("count", `SPR_IDX_CNT0, 32'h3);
    rdc("count", `SPR_IDX_CNT1, 32'h0);
    rdc("count", `SPR_IDX_CNT2, 32'h3);
    rdc("count", `SPR_IDX_CNT0, 32'h0);
    $display("counter test done");
    @(posedge clk);
    pd <= 1'h1;
    @(posedge clk);
    pd <= 1'h0;
    repeat (3) @(posedge clk);
    #1 cmp("irq", 32'h0, {31'h0, irq});
    bus(`SPR_IDX_IMR, 1'h1, 32'h0);
    repeat (2) @(posedge clk);
    #1 cmp("irq", 32'h1, {31'h0, irq});
    rdc("pending", `SPR_IDX_IPR, 32'h1);
    repeat (2) @(posedge clk);
    #1 cmp("irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    pd <= 1'h1;
    @(posedge clk);
    pd <= 1'h0;
    repeat (2) @(posedge clk);
    #1 cmp("irq", 32'h1, {31'h0, irq});
    bus(`SPR_IDX_IMR, 1'h1, 32'h1);
    repeat (2) @(posedge clk);
    #1 cmp("irq", 32'h0, {31'h0, irq});
    rdc("pending", `SPR_IDX_IPR, 32'h1);
    cmp("evt irq", 32'h0, {31'h0, eirq});
    bus(`SPR_IDX_EVT_MASK, 1'h1, 32'h4);
    repeat (2) @(posedge clk);
    #1 cmp("evt irq", 32'h1, {31'h0, eirq});
    rdc("evt status", `SPR_IDX_EVT_STAT, 32'h6);
    repeat (2) @(posedge clk);
    #1 cmp("evt irq", 32'h0, {31'h0, eirq});
    $display("irq test done");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    test_done;
  end
endmodule // tb_spr_regs
`default_nettype wire
